// File: logic/exec_cfg.svh
// Offsets, field positions, reset values and cycle counts of the executor
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
`define OFS_INSTR 12'h000
`define OFS_STATUS 12'h004
`define OFS_WORK 12'h008
`define OFS_PCH 12'h00C
`define OFS_TABLE_HIGH_POINTER 12'h010
`define OFS_PC 12'h014
`define OFS_STACK 12'h018
`define FILE_PAGE 4'h1
`define ST_GIE_BIT 0
`define ST_ZERO_BIT 1
`define ST_BUSY_BIT 2
`define IW_OP_MSB 15
`define IW_OP_LSB 12
`define IW_ARG_MSB 8
`define IW_DEST_BIT 6
`define IW_REG_MSB 5
`define OPC_IRQ_OFF 4'h1
`define OPC_IRQ_ON 4'h2
`define OPC_JUMP_IMM 4'h3
`define OPC_JUMP_WREG 4'h4
`define OPC_ADD_ONE 4'h5
`define OPC_TRAP 4'h6
`define PCH_JUMP_BIT 1
`define TRAP_VECTOR 10'h001
`define CYC_SINGLE 2'h1
`define CYC_JUMP 2'h2
`define CYC_TRAP 2'h3
`define RST_GIE 1'h0
`define RST_ZERO 1'h0
`define RST_PC 10'h000
`define RST_BYTE 8'h00
`define RST_HIGH 2'h0
`endif

// File: logic/exec_pkg.sv
// Types shared by the executor files
`default_nettype none
package exec_pkg;
  typedef enum logic [2:0] {OP_NOP, OP_IRQ_OFF, OP_IRQ_ON, OP_JUMP_IMM, OP_JUMP_WREG, OP_ADD_ONE, OP_TRAP} op_e;
  typedef enum {BUS_IDLE, BUS_WAIT} bus_e;
  typedef enum {EX_IDLE, EX_RUN} ex_e;
  typedef enum {R_INSTR, R_STATUS, R_WORK, R_PCH, R_TABLE_HIGH_POINTER, R_PC, R_STACK, R_FILE, R_NONE} reg_e;
  typedef struct packed
  {
    logic [11:0] addr;
    logic mapped;
    logic write;
  } bus_req_s;
endpackage
`default_nettype wire

// File: logic/file_regs.sv
// Sixty-four file registers, one write port and two read ports
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"
module file_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [7:0] wdata,
  // Read ports
  input wire logic [5:0] raddr_a,
  output logic [7:0] rdata_a,
  input wire logic [5:0] raddr_b,
  output logic [7:0] rdata_b
);
  logic [7:0] mem [0:63];

  genvar i;
  generate
    for (i = 0; i < 64; i = i + 1)
    begin : g_entry
      logic [7:0] next_val;
      always_comb
      begin
        next_val = mem[i];
        if (we && waddr == 6'(i))
          next_val = wdata;
      end
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          mem[i] <= `RST_BYTE;
        else
          mem[i] <= next_val;
      end
    end
  endgenerate

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule // file_regs
`default_nettype wire

// File: logic/mcu_branch_irq_add_one_op_exec.sv
// Executor for interrupt enable, jumps, increment and software trap
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"
module mcu_branch_irq_add_one_op_exec (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Core state
  output logic GLOBAL_IRQ_ENABLE,
  output logic [9:0] PROG_COUNTER
);
  import exec_pkg::*;

  function automatic reg_e reg_sel(input bus_req_s r);
    reg_sel = R_NONE;
    if (r.mapped && r.addr[11:8] == `FILE_PAGE)
      reg_sel = R_FILE;
    else if (r.mapped)
      case (r.addr)
        `OFS_INSTR: reg_sel = R_INSTR;
        `OFS_STATUS: reg_sel = R_STATUS;
        `OFS_WORK: reg_sel = R_WORK;
        `OFS_PCH: reg_sel = R_PCH;
        `OFS_TABLE_HIGH_POINTER: reg_sel = R_TABLE_HIGH_POINTER;
        `OFS_PC: reg_sel = R_PC;
        `OFS_STACK: reg_sel = R_STACK;
        default: reg_sel = R_NONE;
      endcase
  endfunction

  function automatic op_e op_decode(input logic [3:0] code);
    case (code)
      `OPC_IRQ_OFF: op_decode = OP_IRQ_OFF;
      `OPC_IRQ_ON: op_decode = OP_IRQ_ON;
      `OPC_JUMP_IMM: op_decode = OP_JUMP_IMM;
      `OPC_JUMP_WREG: op_decode = OP_JUMP_WREG;
      `OPC_ADD_ONE: op_decode = OP_ADD_ONE;
      `OPC_TRAP: op_decode = OP_TRAP;
      default: op_decode = OP_NOP;
    endcase
  endfunction

  function automatic logic [1:0] op_cycles(input op_e op);
    case (op)
      OP_JUMP_IMM: op_cycles = `CYC_JUMP;
      OP_JUMP_WREG: op_cycles = `CYC_JUMP;
      OP_TRAP: op_cycles = `CYC_TRAP;
      default: op_cycles = `CYC_SINGLE;
    endcase
  endfunction

  // Reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Bus slave state
  bus_e bus_state, next_bus_state;
  bus_req_s req, next_req;
  logic hready_q, next_hready;
  logic [31:0] rdata, next_rdata;
  logic wr_en;
  reg_e sel;

  // Executor state
  ex_e ex_state, next_ex_state;
  op_e ex_op, next_ex_op;
  logic [1:0] cnt, next_cnt;
  logic [9:0] target, next_target;
  logic global_irq_enable, next_gie;
  logic zf, next_zf;
  logic [7:0] wreg, next_wreg;
  logic [1:0] pch, next_pch;
  logic [1:0] table_high_pointer, next_table_high_pointer;
  logic [9:0] pc, next_pc;
  logic [9:0] stk [0:3];
  logic [9:0] next_stk [0:3];
  logic [1:0] sp, next_sp;
  logic [9:0] stack_top;
  logic busy;
  logic start;
  op_e op_now;
  logic [7:0] sum;

  // File register ports
  logic fr_we;
  logic [5:0] fr_wa;
  logic [7:0] fr_wd;
  logic [7:0] fr_rd_a;
  logic [7:0] fr_rd_b;

  assign busy = (ex_state == EX_RUN);
  assign sel = reg_sel(req);
  assign stack_top = stk[sp - 2'h1];
  assign start = wr_en && sel == R_INSTR;
  assign op_now = op_decode(HWDATA[`IW_OP_MSB:`IW_OP_LSB]);
  assign sum = fr_rd_a + 8'h01;

  file_regs u_file_regs (
    .clk(CLOCK),
    .rst_n(rst_n),
    .we(fr_we),
    .waddr(fr_wa),
    .wdata(fr_wd),
    .raddr_a(HWDATA[`IW_REG_MSB:0]),
    .rdata_a(fr_rd_a),
    .raddr_b(req.addr[7:2]),
    .rdata_b(fr_rd_b)
  );

  // Bus: one wait state per transfer, instruction writes stall while busy
  always_comb
  begin
    next_bus_state = bus_state;
    next_req = req;
    next_hready = hready_q;
    next_rdata = rdata;
    wr_en = 1'b0;
    case (bus_state)
      BUS_IDLE:
        if (HSEL && HREADY && HTRANS[1])
        begin
          next_req.addr = HADDR[11:0];
          next_req.mapped = (HADDR[31:12] == 20'h00000);
          next_req.write = HWRITE;
          next_hready = 1'b0;
          next_bus_state = BUS_WAIT;
        end
      BUS_WAIT:
        if (!(req.write && sel == R_INSTR && busy))
        begin
          wr_en = req.write;
          next_hready = 1'b1;
          next_bus_state = BUS_IDLE;
          next_rdata = 32'h00000000;
          if (!req.write)
            case (sel)
              R_STATUS: next_rdata = {29'h00000000, busy, zf, global_irq_enable};
              R_WORK: next_rdata = {24'h000000, wreg};
              R_PCH: next_rdata = {30'h00000000, pch};
              R_TABLE_HIGH_POINTER: next_rdata = {30'h00000000, table_high_pointer};
              R_PC: next_rdata = {22'h000000, pc};
              R_STACK: next_rdata = {22'h000000, stack_top};
              R_FILE: next_rdata = {24'h000000, fr_rd_b};
              default: next_rdata = 32'h00000000;
            endcase
        end
      default: next_bus_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_state <= BUS_IDLE;
      req <= '0;
      hready_q <= 1'b1;
      rdata <= 32'h00000000;
    end
    else
    begin
      bus_state <= next_bus_state;
      req <= next_req;
      hready_q <= next_hready;
      rdata <= next_rdata;
    end
  end

  // Executor: single-cycle ops finish at issue, others count down
  always_comb
  begin
    next_ex_state = ex_state;
    next_ex_op = ex_op;
    next_cnt = cnt;
    next_target = target;
    next_gie = global_irq_enable;
    next_zf = zf;
    next_wreg = wreg;
    next_pch = pch;
    next_table_high_pointer = table_high_pointer;
    next_pc = pc;
    next_stk = stk;
    next_sp = sp;
    fr_we = 1'b0;
    fr_wa = req.addr[7:2];
    fr_wd = HWDATA[7:0];
    if (wr_en)
      case (sel)
        R_STATUS:
        begin
          next_gie = HWDATA[`ST_GIE_BIT];
          next_zf = HWDATA[`ST_ZERO_BIT];
        end
        R_WORK: next_wreg = HWDATA[7:0];
        R_PCH: next_pch = HWDATA[1:0];
        R_TABLE_HIGH_POINTER: next_table_high_pointer = HWDATA[1:0];
        R_PC: next_pc = HWDATA[9:0];
        R_FILE: fr_we = 1'b1;
        default: next_pc = pc;
      endcase
    case (ex_state)
      EX_IDLE:
        if (start)
        begin
          next_ex_op = op_now;
          next_pc = pc + 10'h001;
          case (op_now)
            OP_IRQ_OFF: next_gie = 1'b0;
            OP_IRQ_ON: next_gie = 1'b1;
            OP_JUMP_IMM: next_target = {pch[`PCH_JUMP_BIT], HWDATA[`IW_ARG_MSB:0]};
            OP_JUMP_WREG: next_target = {table_high_pointer, wreg};
            OP_ADD_ONE:
            begin
              next_zf = (sum == 8'h00);
              if (HWDATA[`IW_DEST_BIT])
              begin
                fr_we = 1'b1;
                fr_wa = HWDATA[`IW_REG_MSB:0];
                fr_wd = sum;
              end
              else
                next_wreg = sum;
            end
            OP_TRAP: next_target = `TRAP_VECTOR;
            default: next_target = target;
          endcase
          if (op_cycles(op_now) != `CYC_SINGLE)
          begin
            next_pc = pc;
            next_cnt = op_cycles(op_now) - 2'h1;
            next_ex_state = EX_RUN;
          end
        end
      EX_RUN:
        if (cnt == 2'h1)
        begin
          next_pc = target;
          if (ex_op == OP_TRAP)
          begin
            next_stk[sp] = pc + 10'h001;
            next_sp = sp + 2'h1;
          end
          next_ex_state = EX_IDLE;
        end
        else
          next_cnt = cnt - 2'h1;
      default: next_ex_state = EX_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ex_state <= EX_IDLE;
      ex_op <= OP_NOP;
      cnt <= 2'h0;
      target <= `RST_PC;
      global_irq_enable <= `RST_GIE;
      zf <= `RST_ZERO;
      wreg <= `RST_BYTE;
      pch <= `RST_HIGH;
      table_high_pointer <= `RST_HIGH;
      pc <= `RST_PC;
      stk <= '{default: `RST_PC};
      sp <= 2'h0;
    end
    else
    begin
      ex_state <= next_ex_state;
      ex_op <= next_ex_op;
      cnt <= next_cnt;
      target <= next_target;
      global_irq_enable <= next_gie;
      zf <= next_zf;
      wreg <= next_wreg;
      pch <= next_pch;
      table_high_pointer <= next_table_high_pointer;
      pc <= next_pc;
      stk <= next_stk;
      sp <= next_sp;
    end
  end

  assign HRDATA = rdata;
  assign HREADYOUT = hready_q;
  assign HRESP = 1'b0;
  assign GLOBAL_IRQ_ENABLE = global_irq_enable;
  assign PROG_COUNTER = pc;

  // Checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!rst_n);

  sequence jump_wait_s;
    busy ##1 !busy;
  endsequence

  sequence trap_wait_s;
    busy ##1 busy ##1 !busy;
  endsequence

  gie_clear_a: assert property (start && op_now == OP_IRQ_OFF |=> !GLOBAL_IRQ_ENABLE)
    else $error("global enable not cleared");
  gie_set_a: assert property (start && op_now == OP_IRQ_ON |=> GLOBAL_IRQ_ENABLE && !busy)
    else $error("global enable not set in one cycle");
  jump_imm_a: assert property (start && op_now == OP_JUMP_IMM |=> jump_wait_s
    ##0 PROG_COUNTER == {$past(pch[`PCH_JUMP_BIT], 2), $past(HWDATA[`IW_ARG_MSB:0], 2)})
    else $error("immediate jump target or timing wrong");
  jump_wreg_a: assert property (start && op_now == OP_JUMP_WREG |=> jump_wait_s
    ##0 PROG_COUNTER == {$past(table_high_pointer, 2), $past(wreg, 2)})
    else $error("work register jump target or timing wrong");
  add_one_work_a: assert property (start && op_now == OP_ADD_ONE && !HWDATA[`IW_DEST_BIT]
    |=> wreg == $past(fr_rd_a) + 8'h01 && !busy)
    else $error("increment to work register wrong");
  add_one_zero_a: assert property (start && op_now == OP_ADD_ONE |=> zf == ($past(fr_rd_a) == 8'hFF))
    else $error("zero flag wrong after increment");
  trap_push_a: assert property (start && op_now == OP_TRAP |=> trap_wait_s
    ##0 PROG_COUNTER == 10'h001 && stack_top == $past(pc, 3) + 10'h001)
    else $error("trap vector, push or timing wrong");
  gie_off_time_a: assert property (start && op_now == OP_IRQ_OFF |=> !busy && pc == $past(pc) + 10'h001)
    else $error("interrupt-off op not single cycle");
endmodule // mcu_branch_irq_add_one_op_exec
`default_nettype wire

// File: testbench/prog_mem_model.sv
// Program memory model that hands instruction words to the bench
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  // Clock
  input wire logic clk,
  // Load side
  input wire logic load,
  input wire logic [3:0] load_addr,
  input wire logic [15:0] load_word,
  // Fetch side
  input wire logic [3:0] fetch_addr,
  output logic [15:0] fetch_word
);
  logic [15:0] mem [16];
  always_ff @(posedge clk)
  begin
    if (load)
    begin
      mem[load_addr] <= load_word;
    end
  end
  assign fetch_word = mem[fetch_addr];
endmodule // prog_mem_model
`default_nettype wire

// File: testbench/mcu_branch_irq_add_one_op_exec_tb.sv
// Self-checking bench for the instruction executor
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"
module mcu_branch_irq_add_one_op_exec_tb;
  import exec_pkg::*;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic GLOBAL_IRQ_ENABLE;
  logic [9:0] PROG_COUNTER;
  logic ld = 1'b0;
  logic [3:0] slot = 4'h0;
  logic [15:0] lw = 16'h0;
  logic [15:0] fw;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q [$];
  int mismatches = 0;
  int checks_done = 0;
  logic [9:0] pc;
  logic [8:0] adr;
  logic [7:0] v;
  logic [5:0] n;
  logic [1:0] t;
  mcu_branch_irq_add_one_op_exec DUT (.CLOCK(CLOCK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .PROG_COUNTER(PROG_COUNTER));
  prog_mem_model mem_i (.clk(CLOCK), .load(ld), .load_addr(slot), .load_word(lw), .fetch_addr(slot),
    .fetch_word(fw));
  initial
  begin
    forever #12.5 CLOCK = ~CLOCK;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge CLOCK);
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HSIZE <= 3'h2;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    rd_pend <= !w;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    rd_pend <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask
  // Instruction goes through program memory, then into the instruction register
  task automatic exec(input logic [15:0] w);
    @(posedge CLOCK);
    slot <= slot + 4'h1;
    lw <= w;
    ld <= 1'b1;
    @(posedge CLOCK);
    ld <= 1'b0;
    // Word lands in memory at the edge above; fetch it one edge later
    @(posedge CLOCK);
    wr({20'h0, `OFS_INSTR}, {16'h0, fw});
  endtask
  task automatic pc_at(input int k, input logic [9:0] e);
    repeat (k) @(posedge CLOCK);
    #1;
    check("pc", {22'h0, PROG_COUNTER}, {22'h0, e});
  endtask
  always @(posedge CLOCK)
  begin
    if (rd_pend && HREADYOUT === 1'b1)
    begin
      check("read", HRDATA, exp_q.pop_front());
      check("resp", {31'h0, HRESP}, 32'h0);
    end
  end
  task automatic complete_run();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge CLOCK);
    mismatches++;
    complete_run();
  end
  initial
  begin
    void'($urandom(1));
    repeat (20) @(posedge CLOCK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLOCK);
    rd({20'h0, `OFS_STATUS}, 32'h0);
    exec({`OPC_IRQ_ON, 12'h0});
    pc_at(0, 10'h001);
    check("gie", {31'h0, GLOBAL_IRQ_ENABLE}, 32'h1);
    rd({20'h0, `OFS_STATUS}, 32'h1);
    exec({`OPC_IRQ_OFF, 12'h0});
    pc_at(0, 10'h002);
    check("gie", {31'h0, GLOBAL_IRQ_ENABLE}, 32'h0);
    rd({20'h0, `OFS_STATUS}, 32'h0);
    pc = 10'h002;
    for (int k = 1; k < 3; k++)
    begin
      adr = 9'($urandom);
      wr({20'h0, `OFS_PCH}, k);
      exec({`OPC_JUMP_IMM, 3'h0, adr});
      pc = {k[1], adr};
      pc_at(0, pc);
      pc_at(1, pc);
    end
    t = 2'($urandom);
    v = 8'($urandom);
    wr({20'h0, `OFS_TABLE_HIGH_POINTER}, {30'h0, t});
    wr({20'h0, `OFS_WORK}, {24'h0, v});
    exec({`OPC_JUMP_WREG, 12'h0});
    pc = {t, v};
    pc_at(0, pc);
    pc_at(1, pc);
    wr(32'h1FC, 32'hFF);
    exec({`OPC_ADD_ONE, 5'h0, 1'b1, 6'h3F});
    pc_at(0, pc + 10'h1);
    rd(32'h1FC, 32'h0);
    rd({20'h0, `OFS_STATUS}, 32'h2);
    n = 6'($urandom);
    v = 8'($urandom);
    wr(32'h100 + {24'h0, n, 2'h0}, {24'h0, v});
    exec({`OPC_ADD_ONE, 5'h0, 1'b0, n});
    rd({20'h0, `OFS_WORK}, {24'h0, v + 8'h1});
    rd(32'h100 + {24'h0, n, 2'h0}, {24'h0, v});
    rd({20'h0, `OFS_STATUS}, {30'h0, v == 8'hFF, 1'b0});
    wr({20'h0, `OFS_PC}, 32'h155);
    exec({`OPC_TRAP, 12'h0});
    pc_at(0, 10'h155);
    pc_at(1, `TRAP_VECTOR);
    pc_at(1, `TRAP_VECTOR);
    rd({20'h0, `OFS_STACK}, 32'h156);
    rd(32'h800, 32'h0);
    rd({20'h0, `OFS_INSTR}, 32'h0);
    complete_run();
  end
endmodule // mcu_branch_irq_add_one_op_exec_tb
`default_nettype wire
